/* File: include/jtsp_pkg.sv */
package jtsp_pkg;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} jtsp_tap_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic rst_n;
	} jtsp_pins_t;

	typedef struct packed {
		logic write;
		logic [35:0] addr;
		logic [31:0] wdata;
	} jtsp_sb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} jtsp_sb_rsp_t;

endpackage : jtsp_pkg

/* File: include/jtsp_regs.svh */
`ifndef JTSP_REGS_SVH
`define JTSP_REGS_SVH

`define JTSP_IR_W 5
`define JTSP_DR_W 37
`define JTSP_BSC_LEN 8
`define JTSP_IR_CAPTURE 5'h01
`define JTSP_IR_EXTEST 5'h00
`define JTSP_IR_IDCODE 5'h01
`define JTSP_IR_SAMPLE 5'h02
`define JTSP_IR_RESET 5'h0C
`define JTSP_IR_SB_ADDR 5'h10
`define JTSP_IR_SB_DATA 5'h11
`define JTSP_IR_BYPASS 5'h1F
`define JTSP_LEN_ID 6'h20
`define JTSP_LEN_BYPASS 6'h01
`define JTSP_LEN_BSC 6'h08
`define JTSP_LEN_RESET 6'h01
`define JTSP_LEN_SB_ADDR 6'h25
`define JTSP_LEN_SB_DATA 6'h21
// Arbitrary identification value; bit 0 is one as a scan marker.
`define JTSP_IDCODE 32'h0A5C3001

`endif

/* File: logic/jtsp_svc_bus.sv */
`timescale 1ns/100ps
`include "jtsp_regs.svh"
module jtsp_svc_bus (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire logic i_upd_addr, // Address register update pulse.
	input wire logic i_upd_data, // Data register update pulse.
	input wire logic [`JTSP_DR_W-1:0] i_dr, // Scanned data register.
	input wire jtsp_pkg::jtsp_sb_rsp_t i_rsp, // Service bus answer.
	output jtsp_pkg::jtsp_sb_req_t o_req, // Service bus request.
	output logic o_valid, // One-cycle request strobe.
	output logic o_busy, // Access in progress.
	output logic [31:0] o_rdata // Last read data.
);
	// A request arriving while busy is dropped; the busy bit scanned out
	// tells the debugger to repeat it.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_req <= '0;
			o_valid <= 1'b0;
			o_busy <= 1'b0;
			o_rdata <= 32'h00000000;
		end else begin
			o_valid <= 1'b0;
			if (i_rsp.ack) begin
				o_busy <= 1'b0;
				if (!o_req.write) begin
					o_rdata <= i_rsp.rdata;
				end
			end
			if (i_upd_addr && !o_busy) begin
				o_req.addr <= i_dr[36:1];
				o_req.write <= i_dr[0];
				if (!i_dr[0]) begin
					o_busy <= 1'b1;
					o_valid <= 1'b1;
				end
			end
			if (i_upd_data && !o_busy && o_req.write) begin
				o_req.wdata <= i_dr[32:1];
				o_busy <= 1'b1;
				o_valid <= 1'b1;
			end
		end
	end
endmodule : jtsp_svc_bus

/* File: logic/jtsp_sync.sv */
`timescale 1ns/100ps
module jtsp_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire logic [W-1:0] i_d, // Asynchronous inputs.
	output logic [W-1:0] o_q // Synchronised inputs.
);
	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			meta_q <= '0;
			o_q <= '0;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule : jtsp_sync

/* File: logic/jtsp_top.sv */
// Behaviour
// - TMS sampled on rising TCK advances TAP.
// - TDI captured on rising TCK while shifting.
// - TDO updated on falling TCK edge.
// - TAP driven by TCK, synchronised to system.
// - Reset release enables pins if TCK low.
// - Enabled scan pins disconnect peripheral functions.
// - Shift path is IR or one DR.
// - Least significant bit shifted first.
// - TDO high impedance outside shift states.
// - Five TMS highs reach test-logic-reset.
// - One TMS low leaves reset for idle.
// - Instruction register is five bits wide.
// - Loaded instruction selects the data register.
// - Identification, bypass, boundary and reset registers.
// - Service bus address and data registers.
// - Instruction latched only entering update-IR.
// - Captured values shift out, latched in update-DR.
// - Reset state selects identification instruction.
`timescale 1ns/100ps
`include "jtsp_regs.svh"
module jtsp_top (
	input wire logic i_sys_clk, // System clock, 25 MHz.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire jtsp_pkg::jtsp_pins_t i_pins, // Raw scan and reset pins.
	input wire logic [`JTSP_BSC_LEN-1:0] i_bsc_pin_in, // Pin levels.
	input wire jtsp_pkg::jtsp_sb_rsp_t i_sb_rsp, // Service bus answer.
	output logic o_tdo, // Serial test data out.
	output logic o_tdo_oe_n, // TDO drive enable, active low.
	output logic o_scan_pins_en, // Pins owned by the scan port.
	output logic o_hold_reset, // Hold device in reset.
	output logic o_extest, // Boundary cells drive the pins.
	output logic [`JTSP_BSC_LEN-1:0] o_bsc_pin_out, // Pin drive values.
	output jtsp_pkg::jtsp_sb_req_t o_sb_req, // Service bus request.
	output logic o_sb_valid, // Service bus request strobe.
	output jtsp_pkg::jtsp_tap_t o_tap_state // Current TAP state.
);
	localparam int SYNC_W = 4 + `JTSP_BSC_LEN;

	jtsp_pkg::jtsp_pins_t pins_s;
	logic [`JTSP_BSC_LEN-1:0] bsc_in_s;
	logic [SYNC_W-1:0] sync_q;
	logic tck_prev_q;
	logic rst_prev_q;
	logic tck_rise;
	logic tck_fall;
	logic en_q;
	jtsp_pkg::jtsp_tap_t state_q;
	jtsp_pkg::jtsp_tap_t state_d;
	logic [`JTSP_IR_W-1:0] ir_sh_q;
	logic [`JTSP_IR_W-1:0] ir_q;
	logic [`JTSP_DR_W-1:0] dr_q;
	logic [5:0] dr_len;
	logic upd_dr;
	logic sb_busy;
	logic [31:0] sb_rdata;

	// Next TAP state for a given TMS level.
	function automatic jtsp_pkg::jtsp_tap_t next_state(
		input jtsp_pkg::jtsp_tap_t s,
		input logic tms
	);
		jtsp_pkg::jtsp_tap_t n;
		n = s;
		case (s)
			jtsp_pkg::TAP_RESET: n = tms ? jtsp_pkg::TAP_RESET
				: jtsp_pkg::TAP_IDLE;
			jtsp_pkg::TAP_IDLE: n = tms ? jtsp_pkg::TAP_SEL_DR
				: jtsp_pkg::TAP_IDLE;
			jtsp_pkg::TAP_SEL_DR: n = tms ? jtsp_pkg::TAP_SEL_IR
				: jtsp_pkg::TAP_CAP_DR;
			jtsp_pkg::TAP_CAP_DR: n = tms ? jtsp_pkg::TAP_EXIT1_DR
				: jtsp_pkg::TAP_SHIFT_DR;
			jtsp_pkg::TAP_SHIFT_DR: n = tms ? jtsp_pkg::TAP_EXIT1_DR
				: jtsp_pkg::TAP_SHIFT_DR;
			jtsp_pkg::TAP_EXIT1_DR: n = tms ? jtsp_pkg::TAP_UPD_DR
				: jtsp_pkg::TAP_PAUSE_DR;
			jtsp_pkg::TAP_PAUSE_DR: n = tms ? jtsp_pkg::TAP_EXIT2_DR
				: jtsp_pkg::TAP_PAUSE_DR;
			jtsp_pkg::TAP_EXIT2_DR: n = tms ? jtsp_pkg::TAP_UPD_DR
				: jtsp_pkg::TAP_SHIFT_DR;
			jtsp_pkg::TAP_UPD_DR: n = tms ? jtsp_pkg::TAP_SEL_DR
				: jtsp_pkg::TAP_IDLE;
			jtsp_pkg::TAP_SEL_IR: n = tms ? jtsp_pkg::TAP_RESET
				: jtsp_pkg::TAP_CAP_IR;
			jtsp_pkg::TAP_CAP_IR: n = tms ? jtsp_pkg::TAP_EXIT1_IR
				: jtsp_pkg::TAP_SHIFT_IR;
			jtsp_pkg::TAP_SHIFT_IR: n = tms ? jtsp_pkg::TAP_EXIT1_IR
				: jtsp_pkg::TAP_SHIFT_IR;
			jtsp_pkg::TAP_EXIT1_IR: n = tms ? jtsp_pkg::TAP_UPD_IR
				: jtsp_pkg::TAP_PAUSE_IR;
			jtsp_pkg::TAP_PAUSE_IR: n = tms ? jtsp_pkg::TAP_EXIT2_IR
				: jtsp_pkg::TAP_PAUSE_IR;
			jtsp_pkg::TAP_EXIT2_IR: n = tms ? jtsp_pkg::TAP_UPD_IR
				: jtsp_pkg::TAP_SHIFT_IR;
			jtsp_pkg::TAP_UPD_IR: n = tms ? jtsp_pkg::TAP_SEL_DR
				: jtsp_pkg::TAP_IDLE;
			default: n = jtsp_pkg::TAP_RESET;
		endcase
		return n;
	endfunction : next_state

	// Length of the data register chosen by an instruction.
	function automatic logic [5:0] len_of(input logic [`JTSP_IR_W-1:0] ir);
		logic [5:0] l;
		l = `JTSP_LEN_BYPASS;
		case (ir)
			`JTSP_IR_IDCODE: l = `JTSP_LEN_ID;
			`JTSP_IR_EXTEST: l = `JTSP_LEN_BSC;
			`JTSP_IR_SAMPLE: l = `JTSP_LEN_BSC;
			`JTSP_IR_RESET: l = `JTSP_LEN_RESET;
			`JTSP_IR_SB_ADDR: l = `JTSP_LEN_SB_ADDR;
			`JTSP_IR_SB_DATA: l = `JTSP_LEN_SB_DATA;
			default: l = `JTSP_LEN_BYPASS;
		endcase
		return l;
	endfunction : len_of

	// Shift right one place, entering the new bit at the chain's top.
	function automatic logic [`JTSP_DR_W-1:0] shift_in(
		input logic [`JTSP_DR_W-1:0] r,
		input logic [5:0] len,
		input logic bit_in
	);
		logic [`JTSP_DR_W-1:0] s;
		s = r >> 1;
		s[len - 6'h01] = bit_in;
		return s;
	endfunction : shift_in

	// TCK is only sampled here; its edges become enable pulses.
	jtsp_sync #(
		.W(SYNC_W)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_d({i_pins, i_bsc_pin_in}),
		.o_q(sync_q)
	);

	assign pins_s = sync_q[SYNC_W-1 -: 4];
	assign bsc_in_s = sync_q[`JTSP_BSC_LEN-1:0];
	assign tck_rise = pins_s.tck & ~tck_prev_q;
	assign tck_fall = ~pins_s.tck & tck_prev_q;
	assign state_d = next_state(state_q, pins_s.tms);
	assign dr_len = len_of(ir_q);
	assign upd_dr = tck_rise && state_d == jtsp_pkg::TAP_UPD_DR;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			tck_prev_q <= 1'b0;
			rst_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= pins_s.tck;
			rst_prev_q <= pins_s.rst_n;
		end
	end

	// Pin ownership is decided once per reset release and kept after.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			en_q <= 1'b0;
		end else if (pins_s.rst_n && !rst_prev_q) begin
			en_q <= ~pins_s.tck;
		end
	end

	// Shared pins leave the peripherals while the scan port owns them.
	assign o_scan_pins_en = en_q;
	assign o_tap_state = state_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !en_q) begin
			state_q <= jtsp_pkg::TAP_RESET;
		end else if (tck_rise) begin
			state_q <= state_d;
		end
	end

	// Instruction shift and parallel registers.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ir_sh_q <= `JTSP_IR_CAPTURE;
			ir_q <= `JTSP_IR_IDCODE;
		end else if (state_q == jtsp_pkg::TAP_RESET) begin
			ir_q <= `JTSP_IR_IDCODE;
		end else if (tck_rise) begin
			case (state_q)
				jtsp_pkg::TAP_CAP_IR: begin
					ir_sh_q <= `JTSP_IR_CAPTURE;
				end
				jtsp_pkg::TAP_SHIFT_IR: begin
					ir_sh_q <= {pins_s.tdi, ir_sh_q[4:1]};
				end
				default: begin
				end
			endcase
			if (state_d == jtsp_pkg::TAP_UPD_IR) begin
				ir_q <= ir_sh_q;
			end
		end
	end

	// Data shift register shared by all data registers.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			dr_q <= '0;
		end else if (tck_rise) begin
			case (state_q)
				jtsp_pkg::TAP_CAP_DR: begin
					dr_q <= '0;
					case (ir_q)
						`JTSP_IR_IDCODE: dr_q[31:0] <= `JTSP_IDCODE;
						`JTSP_IR_EXTEST, `JTSP_IR_SAMPLE: begin
							dr_q[`JTSP_BSC_LEN-1:0] <= bsc_in_s;
						end
						`JTSP_IR_RESET: dr_q[0] <= o_hold_reset;
						`JTSP_IR_SB_ADDR: dr_q[0] <= sb_busy;
						`JTSP_IR_SB_DATA: begin
							dr_q[32:0] <= {sb_rdata, sb_busy};
						end
						default: dr_q[0] <= 1'b0;
					endcase
				end
				jtsp_pkg::TAP_SHIFT_DR: begin
					dr_q <= shift_in(dr_q, dr_len, pins_s.tdi);
				end
				default: begin
				end
			endcase
		end
	end

	// Parallel outputs of boundary and reset registers.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_bsc_pin_out <= '0;
			o_hold_reset <= 1'b0;
		end else if (state_q == jtsp_pkg::TAP_RESET) begin
			o_hold_reset <= 1'b0;
		end else if (upd_dr) begin
			case (ir_q)
				`JTSP_IR_EXTEST, `JTSP_IR_SAMPLE: begin
					o_bsc_pin_out <= dr_q[`JTSP_BSC_LEN-1:0];
				end
				`JTSP_IR_RESET: o_hold_reset <= dr_q[0];
				default: begin
				end
			endcase
		end
	end

	// Cells drive the pins as soon as the instruction is active.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_extest <= 1'b0;
		end else begin
			o_extest <= ir_q == `JTSP_IR_EXTEST;
		end
	end

	// TDO moves on the falling edge so it is stable at the next rise.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_tdo <= 1'b0;
			o_tdo_oe_n <= 1'b1;
		end else if (!en_q) begin
			o_tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			if (state_q == jtsp_pkg::TAP_SHIFT_IR) begin
				o_tdo <= ir_sh_q[0];
				o_tdo_oe_n <= 1'b0;
			end else if (state_q == jtsp_pkg::TAP_SHIFT_DR) begin
				o_tdo <= dr_q[0];
				o_tdo_oe_n <= 1'b0;
			end else begin
				o_tdo_oe_n <= 1'b1;
			end
		end
	end

	jtsp_svc_bus u_svc (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_upd_addr(upd_dr && ir_q == `JTSP_IR_SB_ADDR),
		.i_upd_data(upd_dr && ir_q == `JTSP_IR_SB_DATA),
		.i_dr(dr_q),
		.i_rsp(i_sb_rsp),
		.o_req(o_sb_req),
		.o_valid(o_sb_valid),
		.o_busy(sb_busy),
		.o_rdata(sb_rdata)
	);

endmodule : jtsp_top

/* File: tb/jtsp_dbg_model.sv */
`timescale 1ns/100ps
module jtsp_dbg_model (
	input wire logic i_sys_clk, // Pacing clock.
	input wire logic i_tdo, // Serial data wire.
	output jtsp_pkg::jtsp_pins_t o_pins // Scan and reset pins.
);
	initial o_pins = '0;
	task automatic wt(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : wt
	// Output bits are read at the fall, since the port only moves them later.
	task automatic cyc(input logic tms, input logic tdi, output logic tdo);
		o_pins.tms = tms;
		o_pins.tdi = tdi;
		wt(4);
		o_pins.tck = 1'b1;
		wt(4);
		tdo = i_tdo;
		o_pins.tck = 1'b0;
	endtask : cyc
	// The clock level is set a cycle after reset falls, since a scan may
	// have lowered the clock in this same instant.
	task automatic pin_rst(input logic tck);
		o_pins.rst_n = 1'b0;
		wt(1);
		o_pins.tck = tck;
		wt(4);
		o_pins.rst_n = 1'b1;
		wt(8);
		o_pins.tck = 1'b0;
		wt(4);
	endtask : pin_rst
	task automatic reset5();
		logic t;
		repeat (5) cyc(1'b1, 1'b0, t);
		cyc(1'b0, 1'b0, t);
	endtask : reset5
	task automatic scan(input logic ir, input logic [63:0] din, input int n,
		output logic [63:0] dout);
		logic t;
		dout = '0;
		cyc(1'b1, 1'b0, t);
		if (ir) cyc(1'b1, 1'b0, t);
		cyc(1'b0, 1'b0, t);
		cyc(1'b0, 1'b0, t);
		for (int i = 0; i < n; i++) cyc(i == n - 1, din[i], dout[i]);
		cyc(1'b1, 1'b0, t);
		cyc(1'b0, 1'b0, t);
	endtask : scan
endmodule : jtsp_dbg_model

/* File: tb/jtsp_top_asserts.sv */
`timescale 1ns/100ps
`include "jtsp_regs.svh"
module jtsp_top_asserts (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_reset, // Synchronous reset.
	input wire jtsp_pkg::jtsp_pins_t i_pins, // Raw pins.
	input wire logic o_tdo, // Serial out.
	input wire logic o_tdo_oe_n, // Serial out enable.
	input wire logic o_scan_pins_en, // Port owns pins.
	input wire logic o_hold_reset, // Reset hold.
	input wire logic o_extest, // Boundary drive.
	input wire logic [`JTSP_BSC_LEN-1:0] o_bsc_pin_out, // Pin values.
	input wire logic o_sb_valid, // Bus strobe.
	input wire jtsp_pkg::jtsp_tap_t o_tap_state // TAP state.
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	logic tck_q;
	logic rise;
	logic [2:0] hi_q;
	assign rise = i_pins.tck && !tck_q;
	always_ff @(posedge i_sys_clk) tck_q <= i_pins.tck;
	// Pin-side view is earlier than the design's, so the bound allows slack.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !o_scan_pins_en || (rise && !i_pins.tms))
			hi_q <= 3'h0;
		else if (rise && hi_q != 3'h5)
			hi_q <= hi_q + 3'h1;
	end
	a_five_highs: assert property ($rose(hi_q == 3'h5) |->
		##[1:6] o_tap_state == jtsp_pkg::TAP_RESET) else $error("no reset");
	a_state_on_rise: assert property ($changed(o_tap_state) &&
		$past(o_scan_pins_en) |-> $past(i_pins.tck, 2))
		else $error("state moved off rise");
	a_tdo_on_fall: assert property ($changed({o_tdo, o_tdo_oe_n}) &&
		o_scan_pins_en && $past(o_scan_pins_en) |-> !$past(i_pins.tck, 2))
		else $error("tdo moved off fall");
	a_tdo_hiz: assert property (!o_tdo_oe_n |-> o_tap_state inside {
		jtsp_pkg::TAP_SHIFT_IR, jtsp_pkg::TAP_SHIFT_DR,
		jtsp_pkg::TAP_EXIT1_IR, jtsp_pkg::TAP_EXIT1_DR})
		else $error("tdo driven outside shift");
	a_leave_reset: assert property ($changed(o_tap_state) &&
		$past(o_tap_state) == jtsp_pkg::TAP_RESET |->
		o_tap_state == jtsp_pkg::TAP_IDLE && !$past(i_pins.tms, 2))
		else $error("bad exit from reset");
	a_pins_off: assert property (!o_scan_pins_en [*3] |->
		o_tap_state == jtsp_pkg::TAP_RESET && o_tdo_oe_n)
		else $error("disabled port active");
	a_ir_latch: assert property ($changed(o_extest) |->
		o_tap_state inside {jtsp_pkg::TAP_UPD_IR, jtsp_pkg::TAP_RESET})
		else $error("instruction moved off update");
	a_dr_latch: assert property ($changed({o_hold_reset,
		o_bsc_pin_out}) |-> o_tap_state inside {jtsp_pkg::TAP_UPD_DR,
		jtsp_pkg::TAP_RESET}) else $error("data moved off update");
	a_bus_pulse: assert property (o_sb_valid |->
		o_tap_state == jtsp_pkg::TAP_UPD_DR ##1 !o_sb_valid)
		else $error("bad bus strobe");
	c_shift_ir: cover property (o_tap_state == jtsp_pkg::TAP_SHIFT_IR);
	c_bus_req: cover property (o_sb_valid);
	c_extest: cover property ($rose(o_extest));
	c_pause_dr: cover property (o_tap_state == jtsp_pkg::TAP_PAUSE_DR);
endmodule : jtsp_top_asserts
bind jtsp_top jtsp_top_asserts jtsp_top_asserts_i (.i_sys_clk, .i_reset,
	.i_pins, .o_tdo, .o_tdo_oe_n, .o_scan_pins_en, .o_hold_reset, .o_extest,
	.o_bsc_pin_out, .o_sb_valid, .o_tap_state);

/* File: tb/tb_jtsp_tap_scan_port.sv */
`timescale 1ns/100ps
`include "jtsp_regs.svh"
module tb_jtsp_tap_scan_port;
	localparam logic [31:0] RDATA = 32'h5AC30F96;
	localparam logic [35:0] ADR1 = 36'h800000ABC;
	localparam logic [35:0] ADR2 = 36'h313579BDF;
	localparam logic [31:0] WDATA = 32'h2468ACE0;
	logic i_sys_clk;
	logic i_reset;
	logic [`JTSP_BSC_LEN-1:0] pin_in;
	logic [`JTSP_BSC_LEN-1:0] pin_out;
	jtsp_pkg::jtsp_sb_rsp_t sb_rsp;
	jtsp_pkg::jtsp_pins_t pins;
	jtsp_pkg::jtsp_sb_req_t sb_req;
	jtsp_pkg::jtsp_tap_t tap;
	logic tdo, tdo_oe_n, tdo_w, pins_en, hold, extest, sb_valid;
	logic [63:0] d;
	int lat = 3;
	int err_total = 0;
	int tests_run = 0;
	int n_valid = 0;
	assign tdo_w = tdo_oe_n ? 1'bz : tdo;
	// Counts every strobe; a request sent while an answer is pending raises none.
	always @(negedge i_sys_clk) begin
		if (sb_valid) begin
			n_valid++;
		end
	end
	jtsp_top jtsp_top_i (.i_sys_clk, .i_reset, .i_pins(pins),
		.i_bsc_pin_in(pin_in), .i_sb_rsp(sb_rsp), .o_tdo(tdo),
		.o_tdo_oe_n(tdo_oe_n), .o_scan_pins_en(pins_en), .o_hold_reset(hold),
		.o_extest(extest), .o_bsc_pin_out(pin_out), .o_sb_req(sb_req),
		.o_sb_valid(sb_valid), .o_tap_state(tap));
	jtsp_dbg_model jtsp_dbg_model_i (.i_sys_clk, .i_tdo(tdo_w), .o_pins(pins));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic ir(input logic [4:0] c);
		jtsp_dbg_model_i.scan(1'b1, 64'(c), 5, d);
	endtask : ir
	task automatic dr(input logic [63:0] v, input int n);
		jtsp_dbg_model_i.scan(1'b0, v, n, d);
	endtask : dr
	task automatic t_enable();
		jtsp_dbg_model_i.pin_rst(1'b1);
		chk(pins_en, 1'b0);
		ir(`JTSP_IR_BYPASS);
		chk({tap, tdo_oe_n}, {jtsp_pkg::TAP_RESET, 1'b1});
		jtsp_dbg_model_i.pin_rst(1'b0);
		chk(pins_en, 1'b1);
		jtsp_dbg_model_i.reset5();
		chk(tap, jtsp_pkg::TAP_IDLE);
		dr(64'h0, 32);
		chk(d, `JTSP_IDCODE);
		$display("enable and id done");
	endtask : t_enable
	task automatic t_bypass();
		ir(`JTSP_IR_BYPASS);
		chk(d, `JTSP_IR_CAPTURE);
		dr(64'hA5, 8);
		chk(d, 64'h4A);
		ir(5'h15);
		dr(64'hB, 4);
		chk(d, 64'h6);
		$display("bypass done");
	endtask : t_bypass
	task automatic t_boundary();
		ir(`JTSP_IR_SAMPLE);
		dr(64'hC5, 8);
		chk(d, 64'h3C);
		chk(pin_out, 8'hC5);
		ir(`JTSP_IR_EXTEST);
		chk(extest, 1'b1);
		ir(`JTSP_IR_BYPASS);
		chk(extest, 1'b0);
		$display("boundary done");
	endtask : t_boundary
	// Walks both pause loops; every step checks where TMS has led.
	task automatic t_walk();
		logic t;
		logic [16:0] tms;
		jtsp_pkg::jtsp_tap_t seq [17];
		tms = 17'h0D5E5;
		seq = '{jtsp_pkg::TAP_SEL_DR, jtsp_pkg::TAP_CAP_DR,
			jtsp_pkg::TAP_EXIT1_DR, jtsp_pkg::TAP_PAUSE_DR,
			jtsp_pkg::TAP_PAUSE_DR, jtsp_pkg::TAP_EXIT2_DR,
			jtsp_pkg::TAP_UPD_DR, jtsp_pkg::TAP_SEL_DR,
			jtsp_pkg::TAP_SEL_IR, jtsp_pkg::TAP_CAP_IR,
			jtsp_pkg::TAP_EXIT1_IR, jtsp_pkg::TAP_PAUSE_IR,
			jtsp_pkg::TAP_EXIT2_IR, jtsp_pkg::TAP_SHIFT_IR,
			jtsp_pkg::TAP_EXIT1_IR, jtsp_pkg::TAP_UPD_IR,
			jtsp_pkg::TAP_IDLE};
		for (int i = 0; i < 17; i++) begin
			jtsp_dbg_model_i.cyc(tms[i], 1'b1, t);
			chk(tap, seq[i]);
		end
		$display("state walk done");
	endtask : t_walk
	// Sets the hold bit, then five TMS highs from a new reset register scan reach reset and clear it.
	task automatic t_hold();
		logic t;
		ir(`JTSP_IR_RESET);
		dr(64'h1, 1);
		chk(hold, 1'b1);
		for (int i = 0; i < 9; i++) jtsp_dbg_model_i.cyc(i == 0 || i > 3,
			1'b1, t);
		chk({tap, hold}, {jtsp_pkg::TAP_RESET, 1'b0});
		jtsp_dbg_model_i.cyc(1'b0, 1'b0, t);
		$display("hold done");
	endtask : t_hold
	task automatic t_bus();
		ir(`JTSP_IR_SB_ADDR);
		dr({ADR1, 1'b0}, 37);
		chk({sb_req.write, sb_req.addr}, {1'b0, ADR1});
		ir(`JTSP_IR_SB_DATA);
		dr(64'h0, 33);
		chk(d, {RDATA, 1'b0});
		lat = 2000;
		ir(`JTSP_IR_SB_ADDR);
		dr({ADR2, 1'b1}, 37);
		ir(`JTSP_IR_SB_DATA);
		dr(64'(WDATA) << 1, 33);
		chk({sb_req.write, sb_req.addr}, {1'b1, ADR2});
		chk(sb_req.wdata, WDATA);
		ir(`JTSP_IR_SB_ADDR);
		dr({ADR1, 1'b0}, 37);
		chk(sb_req.addr, ADR2);
		chk(n_valid, 2);
		$display("service bus done");
	endtask : t_bus
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		sb_rsp = '0;
		forever begin
			@(negedge i_sys_clk);
			sb_rsp.ack = 1'b0;
			if (sb_valid) begin
				repeat (lat) @(negedge i_sys_clk);
				sb_rsp = {1'b1, RDATA};
			end
		end
	end
	initial begin
		repeat (90000) @(posedge i_sys_clk);
		err_total++;
		close_out();
	end
	initial begin
		i_reset = 1'b1;
		pin_in = 8'h3C;
		repeat (16) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_reset = 1'b0;
		t_enable();
		t_bypass();
		t_walk();
		t_boundary();
		t_hold();
		t_bus();
		close_out();
	end
endmodule : tb_jtsp_tap_scan_port
